// ### common/self_program_pkg.sv
// constants and carriers for the self-programming section control
// assumes a word-addressed flash of 32k words and an 8-bit register port
package self_program_pkg;

    // ------------------------------------------------------------
    // flash geometry
    // ------------------------------------------------------------
    localparam int            FLASH_AW       = 15;
    localparam logic [14:0]   HALT_START     = 15'h7000; // fixed boundary
    // loader start per loader size setting, all inside the halting region
    localparam logic [14:0]   LOADER_START_3 = 15'h7e00;
    localparam logic [14:0]   LOADER_START_2 = 15'h7c00;
    localparam logic [14:0]   LOADER_START_1 = 15'h7800;
    localparam logic [14:0]   LOADER_START_0 = 15'h7000;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [1:0]    OFS_CTRL_STATUS = 2'h0;
    localparam logic [1:0]    OFS_LOCK        = 2'h1;
    localparam logic [1:0]    OFS_IRQ_STATUS  = 2'h2;
    localparam logic [1:0]    OFS_IRQ_MASK    = 2'h3;

    localparam int            BUSY_BIT        = 0;
    localparam int            ACTIVE_BIT      = 1;
    localparam int            HALT_BIT        = 2;

    localparam int            APP_LOW_BIT     = 0;
    localparam int            APP_HIGH_BIT    = 1;
    localparam int            LDR_LOW_BIT     = 2;
    localparam int            LDR_HIGH_BIT    = 3;
    localparam logic [3:0]    LOCK_RESET      = 4'hf; // 1 = unprogrammed

    localparam int            EV_DONE_BIT     = 0;
    localparam int            EV_REFUSED_BIT  = 1;
    localparam logic [1:0]    IRQ_RESET       = 2'h0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_PROG
    } prog_state_e;

    typedef struct packed {
        logic              valid;
        logic              erase;      // 1 = page erase, 0 = page write
        logic [14:0]       addr;       // flash address pointer value
    } store_req_s;

    typedef struct packed {
        prog_state_e       state;
        logic              busyFlag;
        logic              halt;
        logic [3:0]        lock;
        logic [1:0]        irqStatus;
        logic [1:0]        irqMask;
        logic              irq;
        logic [7:0]        rdData;
        logic              flashStart;
        logic              flashErase;
        logic [14:0]       flashAddr;
        logic              loadGrant;
        logic              loadDeny;
    } ctrl_state_s;

endpackage

// ### src/self_program_section_control.sv
// control of flash self-programming: region checks, core halt, busy flag
// assumes the core raises store/load requests for one cycle, the flash
// macro answers each started operation with a one-cycle done pulse
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps

module self_program_section_control (
    input  wire logic                        clock,
    input  wire logic                        rstn,
    input  wire logic [1:0]                  regAddr,
    input  wire logic [7:0]                  regWrData,
    input  wire logic                        regWr,
    input  wire logic                        regRd,
    output logic      [7:0]                  regRdData,
    input  wire logic [1:0]                  loaderSizeFuses,
    input  wire logic                        chipErase,
    input  wire logic                        execInLoader,
    input  wire self_program_pkg::store_req_s storeReq,
    input  wire logic                        loadReq,
    input  wire logic [14:0]                 loadAddr,
    input  wire logic                        flashDone,
    output logic                             flashStart,
    output logic                             flashErase,
    output logic      [14:0]                 flashAddr,
    output logic                             coreHalt,
    output logic                             busyFlag,
    output logic                             loadGrant,
    output logic                             loadDeny,
    output logic                             irq
);

    self_program_pkg::ctrl_state_s  cur;
    self_program_pkg::ctrl_state_s  next_cur;
    logic [14:0]                    loaderStart;
    logic                           tgtInLoader;
    logic                           tgtInHalt;
    logic                           storeOk;
    logic                           loadInLoader;
    logic                           loadCross;
    logic                           loadLocked;

    // ------------------------------------------------------------
    // region decode
    // ------------------------------------------------------------
    // loader start from the size fuses; every choice is at or above the
    // halting boundary so the loader never reads concurrent flash
    always_comb begin
        case (loaderSizeFuses)
            2'h3:    loaderStart = self_program_pkg::LOADER_START_3;
            2'h2:    loaderStart = self_program_pkg::LOADER_START_2;
            2'h1:    loaderStart = self_program_pkg::LOADER_START_1;
            default: loaderStart = self_program_pkg::LOADER_START_0;
        endcase
    end

    // target classification by address pointer value
    assign tgtInHalt   = storeReq.addr >= self_program_pkg::HALT_START;
    assign tgtInLoader = storeReq.addr >= loaderStart;

    // any page may be hit from loader code, subject only to the write
    // lock of the page's own region
    assign storeOk = execInLoader && (tgtInLoader ?
        cur.lock[self_program_pkg::LDR_LOW_BIT] :
        cur.lock[self_program_pkg::APP_LOW_BIT]);

    // loads across the region border are refused when the target
    // region's high lock bit is programmed (zero)
    assign loadInLoader = loadAddr >= loaderStart;
    assign loadCross    = loadInLoader != execInLoader;
    assign loadLocked   = loadCross && (loadInLoader ?
        !cur.lock[self_program_pkg::LDR_HIGH_BIT] :
        !cur.lock[self_program_pkg::APP_HIGH_BIT]);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_cur            = cur;
        next_cur.flashStart = 1'b0;
        next_cur.loadGrant  = 1'b0;
        next_cur.loadDeny   = 1'b0;
        next_cur.rdData     = 8'h00;

        // register writes first so hardware events below win over clears
        if (regWr) begin
            case (regAddr)
                self_program_pkg::OFS_CTRL_STATUS: begin
                    // clear only once the operation is over
                    if (regWrData[self_program_pkg::BUSY_BIT] &&
                        cur.state == self_program_pkg::ST_IDLE) begin
                        next_cur.busyFlag = 1'b0;
                    end
                end
                self_program_pkg::OFS_LOCK: begin
                    // software may only program bits, never erase
                    next_cur.lock = cur.lock & regWrData[3:0];
                end
                self_program_pkg::OFS_IRQ_STATUS: begin
                    next_cur.irqStatus = cur.irqStatus & ~regWrData[1:0];
                end
                self_program_pkg::OFS_IRQ_MASK: begin
                    next_cur.irqMask = regWrData[1:0];
                end
                default: begin
                    next_cur.irqMask = cur.irqMask;
                end
            endcase
        end

        // chip erase and reset are the only ways back to unprogrammed locks
        if (chipErase) begin
            next_cur.lock = self_program_pkg::LOCK_RESET;
        end

        case (cur.state)
            self_program_pkg::ST_IDLE: begin
                if (storeReq.valid) begin
                    if (storeOk) begin
                        next_cur.state      = self_program_pkg::ST_PROG;
                        next_cur.flashStart = 1'b1;
                        next_cur.flashErase = storeReq.erase;
                        next_cur.flashAddr  = storeReq.addr;
                        next_cur.halt       = tgtInHalt;
                        if (!tgtInHalt) begin
                            next_cur.busyFlag = 1'b1;
                        end
                    end else begin
                        // app-region or locked store starts no flash operation, only raises the refused event
                        next_cur.irqStatus[
                            self_program_pkg::EV_REFUSED_BIT] = 1'b1;
                    end
                end
            end
            self_program_pkg::ST_PROG: begin
                // further stores are ignored until the flash is done
                if (flashDone) begin
                    next_cur.state = self_program_pkg::ST_IDLE;
                    next_cur.halt  = 1'b0;
                    next_cur.irqStatus[self_program_pkg::EV_DONE_BIT] = 1'b1;
                end
            end
            default: begin
                next_cur.state = self_program_pkg::ST_IDLE;
                next_cur.halt  = 1'b0;
            end
        endcase

        // loads: none while halted, none into the concurrent region while
        // it is blocked, and none that a lock forbids
        if (loadReq) begin
            if (cur.halt || loadLocked ||
                (cur.busyFlag && loadAddr < self_program_pkg::HALT_START))
            begin
                next_cur.loadDeny  = 1'b1;
            end else begin
                next_cur.loadGrant = 1'b1;
            end
        end

        // read data stand in the cycle after the strobe only
        if (regRd) begin
            case (regAddr)
                self_program_pkg::OFS_CTRL_STATUS: begin
                    next_cur.rdData[self_program_pkg::BUSY_BIT]   =
                        cur.busyFlag;
                    next_cur.rdData[self_program_pkg::ACTIVE_BIT] =
                        cur.state == self_program_pkg::ST_PROG;
                    next_cur.rdData[self_program_pkg::HALT_BIT]   = cur.halt;
                end
                self_program_pkg::OFS_LOCK:
                    next_cur.rdData = {4'h0, cur.lock};
                self_program_pkg::OFS_IRQ_STATUS:
                    next_cur.rdData = {6'h00, cur.irqStatus};
                default:
                    next_cur.rdData = {6'h00, cur.irqMask};
            endcase
        end

        // level interrupt from the registered status and mask
        next_cur.irq = |(next_cur.irqStatus & next_cur.irqMask);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cur            <= '0;
            cur.state      <= self_program_pkg::ST_IDLE;
            cur.lock       <= self_program_pkg::LOCK_RESET;
            cur.irqStatus  <= self_program_pkg::IRQ_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // outputs straight from the state flops
    assign regRdData  = cur.rdData;
    assign flashStart = cur.flashStart;
    assign flashErase = cur.flashErase;
    assign flashAddr  = cur.flashAddr;
    assign coreHalt   = cur.halt;
    assign busyFlag   = cur.busyFlag;
    assign loadGrant  = cur.loadGrant;
    assign loadDeny   = cur.loadDeny;
    assign irq        = cur.irq;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_goodStore;
        cur.state == self_program_pkg::ST_IDLE && storeReq.valid && storeOk;
    endsequence

    sequence s_started;
        flashStart && flashAddr == $past(storeReq.addr);
    endsequence

    property p_appStoreNoEffect;
        @(posedge clock) disable iff (!rstn)
        storeReq.valid && !execInLoader |=> !flashStart;
    endproperty
    a_appStoreNoEffect: assert property (p_appStoreNoEffect)
        else $error("store from application region started flash");

    property p_storeStarts;
        @(posedge clock) disable iff (!rstn)
        s_goodStore |=> s_started;
    endproperty
    a_storeStarts: assert property (p_storeStarts)
        else $error("permitted store did not start flash");

    property p_haltByRegion;
        @(posedge clock) disable iff (!rstn)
        s_goodStore |=> coreHalt == $past(tgtInHalt);
    endproperty
    a_haltByRegion: assert property (p_haltByRegion)
        else $error("halt does not follow target region");

    property p_concurrentRuns;
        @(posedge clock) disable iff (!rstn)
        (s_goodStore and !tgtInHalt) |=> !coreHalt && busyFlag;
    endproperty
    a_concurrentRuns: assert property (p_concurrentRuns)
        else $error("concurrent-region op halted core or no busy");

    property p_haltHeld;
        @(posedge clock) disable iff (!rstn)
        coreHalt && !flashDone |=> coreHalt;
    endproperty
    a_haltHeld: assert property (p_haltHeld)
        else $error("halt dropped before flash done");

    property p_noLoadInHalt;
        @(posedge clock) disable iff (!rstn)
        coreHalt && loadReq |=> loadDeny && !loadGrant;
    endproperty
    a_noLoadInHalt: assert property (p_noLoadInHalt)
        else $error("load granted while core halted");

    property p_loaderInHalt;
        @(posedge clock) disable iff (!rstn)
        loaderStart >= self_program_pkg::HALT_START;
    endproperty
    a_loaderInHalt: assert property (p_loaderInHalt)
        else $error("loader region leaves halting region");

    property p_busyRead;
        @(posedge clock) disable iff (!rstn)
        regRd && regAddr == self_program_pkg::OFS_CTRL_STATUS
        |=> regRdData[self_program_pkg::BUSY_BIT] == $past(busyFlag);
    endproperty
    a_busyRead: assert property (p_busyRead)
        else $error("busy flag read back wrong");

    property p_busySticky;
        @(posedge clock) disable iff (!rstn)
        busyFlag && !(regWr && regAddr == self_program_pkg::OFS_CTRL_STATUS)
        |=> busyFlag;
    endproperty
    a_busySticky: assert property (p_busySticky)
        else $error("busy flag dropped without software clear");

    property p_lockOnlyProgram;
        @(posedge clock) disable iff (!rstn)
        !chipErase |=> (cur.lock & ~$past(cur.lock)) == 4'h0;
    endproperty
    a_lockOnlyProgram: assert property (p_lockOnlyProgram)
        else $error("lock bit erased without chip erase");

    property p_writeLock;
        @(posedge clock) disable iff (!rstn)
        storeReq.valid && execInLoader && !tgtInLoader &&
        !cur.lock[self_program_pkg::APP_LOW_BIT] |=> !flashStart;
    endproperty
    a_writeLock: assert property (p_writeLock)
        else $error("store into write-locked application region");

endmodule

// ### dv/core_flash_model.sv
// partner model: the core issuing stores and loads, plus the flash done
// assumes the control block takes requests on the edge after they rise
`timescale 1ns/1ps

module core_flash_model (
    input  wire logic                   clock,
    input  wire logic                   flashStart,
    output self_program_pkg::store_req_s storeReq,
    output logic                        execInLoader,
    output logic                        loadReq,
    output logic [14:0]                 loadAddr,
    output logic                        flashDone
);
    // quiet core at time zero
    initial begin
        storeReq = '0;
        execInLoader = 1'b0;
        loadReq = 1'b0;
        loadAddr = '0;
        flashDone = 1'b0;
    end

    // one program-store, held a single cycle; released fields are
    // inverted so a design that samples them late sees garbage
    task automatic store(input logic er, input logic [14:0] a,
                         input logic inL);
        @(posedge clock);
        storeReq <= '{valid: 1'b1, erase: er, addr: a};
        execInLoader <= inL;
        @(posedge clock);
        storeReq <= '{valid: 1'b0, erase: ~er, addr: ~a};
        @(negedge clock);
    endtask

    // flash macro answer after lat cycles, prompt or slow
    task automatic finish(input int lat);
        repeat (lat) @(posedge clock);
        flashDone <= 1'b1;
        @(posedge clock);
        flashDone <= 1'b0;
        @(negedge clock);
    endtask

    // program-load; loads into a region under programming are issued
    // only when a scenario asks for a refusal on purpose
    task automatic load(input logic [14:0] a, input logic inL);
        @(posedge clock);
        loadReq <= 1'b1;
        loadAddr <= a;
        execInLoader <= inL;
        @(posedge clock);
        loadReq <= 1'b0;
        loadAddr <= ~a;
        @(negedge clock);
    endtask
endmodule

// ### dv/self_program_section_control_bench.sv
// bench for the self-programming control: register port and core model
// assumes the design's own assertions watch its internal timing
`timescale 1ns/1ps

module self_program_section_control_bench;
    logic clock, rstn, regWr, regRd, chipErase;
    logic [1:0] regAddr, loaderSizeFuses;
    logic [7:0] regWrData, regRdData;
    logic [14:0] loadAddr, flashAddr;
    logic execInLoader, loadReq, flashDone, flashStart, flashErase;
    logic coreHalt, busyFlag, loadGrant, loadDeny, irq;
    self_program_pkg::store_req_s storeReq;
    int errors, n_compared, cycles;
    logic [14:0] starts [4];

    self_program_section_control dut (
        .clock(clock), .rstn(rstn), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .loaderSizeFuses(loaderSizeFuses),
        .chipErase(chipErase), .execInLoader(execInLoader),
        .storeReq(storeReq), .loadReq(loadReq), .loadAddr(loadAddr),
        .flashDone(flashDone), .flashStart(flashStart),
        .flashErase(flashErase), .flashAddr(flashAddr),
        .coreHalt(coreHalt), .busyFlag(busyFlag), .loadGrant(loadGrant),
        .loadDeny(loadDeny), .irq(irq));

    core_flash_model core (
        .clock(clock), .flashStart(flashStart), .storeReq(storeReq),
        .execInLoader(execInLoader), .loadReq(loadReq),
        .loadAddr(loadAddr), .flashDone(flashDone));

    // ------------------------------------------------------------
    // clock, timeout and reporting
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // a hang anywhere ends the run as a failure
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // ------------------------------------------------------------
    // register port, strobes one cycle long
    // ------------------------------------------------------------
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clock);
        regWr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clock);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRd <= 1'b0;
        @(negedge clock);
        check({12'h000, regRdData}, {12'h000, exp});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        starts = '{self_program_pkg::LOADER_START_0,
                   self_program_pkg::LOADER_START_1,
                   self_program_pkg::LOADER_START_2,
                   self_program_pkg::LOADER_START_3};
        errors = 0;
        n_compared = 0;
        cycles = 0;
        rstn = 1'b0;
        {regWr, regRd, chipErase, regAddr, regWrData} = '0;
        loaderSizeFuses = 2'h3;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h0f);
        rd(2'h2, 8'h00);
        rd(2'h3, 8'h00);
        // store from application code is refused, event masked first
        core.store(1'b0, 15'h0100, 1'b0);
        check(flashStart, 1'b0);
        rd(2'h2, 8'h02);
        check(irq, 1'b0);
        wr(2'h3, 8'h03);
        rd(2'h3, 8'h03);
        check(irq, 1'b1);
        wr(2'h2, 8'h02);
        rd(2'h2, 8'h00);
        check(irq, 1'b0);
        // last concurrent word: core runs, halting region stays readable
        core.store(1'b0, 15'h6fff, 1'b1);
        check({flashStart, flashErase, flashAddr, coreHalt, busyFlag},
              {2'b10, 15'h6fff, 2'b01});
        core.load(15'h7000, 1'b1);
        check({loadGrant, loadDeny}, 2'b10);
        core.load(15'h0010, 1'b1);
        check({loadGrant, loadDeny}, 2'b01);
        rd(2'h0, 8'h03);
        wr(2'h0, 8'h01); // early clear must not take
        rd(2'h0, 8'h03);
        // a store while the flash is busy is dropped without a trace
        core.store(1'b1, 15'h7000, 1'b1);
        check({flashStart, coreHalt, flashAddr},
              {2'b00, 15'h6fff});
        core.finish(6);
        check({coreHalt, busyFlag}, 2'b01);
        rd(2'h2, 8'h01);
        check(irq, 1'b1);
        // busy cleared by software before concurrent code runs
        wr(2'h0, 8'h01);
        rd(2'h0, 8'h00);
        wr(2'h2, 8'h01);
        // first halting word: core stalls, every load refused
        core.store(1'b1, 15'h7000, 1'b1);
        check({flashStart, flashErase, flashAddr, coreHalt, busyFlag},
              {2'b11, 15'h7000, 2'b10});
        core.load(15'h7100, 1'b1);
        check({loadGrant, loadDeny}, 2'b01);
        core.finish(1);
        check(coreHalt, 1'b0);
        // every loader size: loader start programmable and halting
        for (int f = 0; f < 4; f++) begin
            @(posedge clock);
            loaderSizeFuses <= f[1:0];
            core.store(1'b1, starts[f], 1'b1);
            check({flashStart, coreHalt}, 2'b11);
            core.finish(1);
        end
        // loader low lock bit blocks the loader only
        wr(2'h1, 8'h0b);
        for (int f = 0; f < 4; f++) begin
            @(posedge clock);
            loaderSizeFuses <= f[1:0];
            core.store(1'b0, starts[f], 1'b1);
            check(flashStart, 1'b0);
            core.store(1'b0, starts[f] - 15'h0001, 1'b1);
            check(flashStart, 1'b1);
            core.finish(2);
            wr(2'h0, 8'h01);
        end
        // lock bits only ever go from one to zero
        wr(2'h1, 8'hff);
        rd(2'h1, 8'h0b);
        wr(2'h1, 8'h0d);
        rd(2'h1, 8'h09);
        core.load(15'h0100, 1'b1);
        check({loadGrant, loadDeny}, 2'b01);
        core.load(15'h0100, 1'b0);
        check({loadGrant, loadDeny}, 2'b10);
        core.load(15'h7e00, 1'b0);
        check({loadGrant, loadDeny}, 2'b10);
        core.store(1'b0, 15'h0100, 1'b1);
        check(flashStart, 1'b1);
        core.finish(1);
        wr(2'h0, 8'h01);
        // every lock programmed: cross-region loads and stores into
        // application pages are both refused
        wr(2'h1, 8'h00);
        rd(2'h1, 8'h00);
        core.load(15'h7e00, 1'b0);
        check({loadGrant, loadDeny}, 2'b01);
        core.store(1'b0, 15'h0100, 1'b1);
        check(flashStart, 1'b0);
        // only a chip erase returns the locks
        @(posedge clock);
        chipErase <= 1'b1;
        @(posedge clock);
        chipErase <= 1'b0;
        rd(2'h1, 8'h0f);
        print_verdict();
    end
endmodule
